// ### alarm_pkg.sv
package alarm_pkg;
    localparam int VALUE_W = 16;
    localparam int TYPE_W = 5;
    localparam int NUM_CH = 2;
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_NS = 50_000_000;
    localparam int CLK_NS = 100;
    localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;
    localparam int DELAY_MAX_S = 999;
    localparam int SEC_CYCLES = CLK_HZ;
    localparam logic [TYPE_W-1:0] TYPE_RESET = 5'h02;
    localparam logic [TYPE_W-1:0] TYPE_OFF = 5'h00;
    localparam logic [TYPE_W-1:0] TYPE_DEV_LO = 5'h03;
    localparam logic [TYPE_W-1:0] TYPE_DEV_LO_SB = 5'h07;
    localparam logic [TYPE_W-1:0] TYPE_ABS_HI = 5'h08;
    localparam logic [TYPE_W-1:0] TYPE_ABS_LO = 5'h09;
    localparam logic [TYPE_W-1:0] TYPE_ABS_HI_SB = 5'h0A;
    localparam logic [TYPE_W-1:0] TYPE_ABS_LO_SB = 5'h0B;
    localparam logic [TYPE_W-1:0] TYPE_LOOP = 5'h0C;
    localparam logic [TYPE_W-1:0] TYPE_RATE = 5'h0D;
    localparam logic [TYPE_W-1:0] TYPE_SP_HI = 5'h0E;
    localparam logic [TYPE_W-1:0] TYPE_SP_LO = 5'h0F;
    localparam logic [TYPE_W-1:0] TYPE_MV_HI = 5'h10;
    localparam logic [TYPE_W-1:0] TYPE_MV_LO = 5'h11;
    localparam logic [3:0] ADDR_TYPE0 = 4'h0;
    localparam logic [3:0] ADDR_THR0 = 4'h1;
    localparam logic [3:0] ADDR_TYPE1 = 4'h2;
    localparam logic [3:0] ADDR_THR1 = 4'h3;
    localparam logic [3:0] ADDR_ON_DLY = 4'h4;
    localparam logic [3:0] ADDR_OFF_DLY = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'h9;
    localparam logic [3:0] ADDR_ALARM = 4'hA;
endpackage : alarm_pkg

// ### alarm_type_evaluator.sv
`timescale 1ns/1ps
// Contract
// - code 7: lower deviation plus standby
// - code 8: alarm when value above threshold
// - code 9: alarm when value below threshold
// - code 10: code 8 plus standby
// - code 11: code 9 plus standby
// - code 12 accepted on channel zero only
// - code 13 selects rate-of-change alarm; accepted but held off, alarm never set
// - code 14: setpoint above threshold
// - code 15: setpoint below threshold
// - code 16: output above threshold, heating level
// - code 17: output below threshold, cooling level in heat/cool mode, heating level otherwise
// - code 3: value below setpoint by threshold
// - code 0 off; reset code is 2
// - on and off delays 0 to 999 s
module alarm_type_evaluator
    import alarm_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES,
    parameter int SEC_DIV = SEC_CYCLES
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic signed [VALUE_W-1:0] process_value,
    input wire logic signed [VALUE_W-1:0] target_setpoint,
    input wire logic signed [VALUE_W-1:0] output_level,
    input wire logic signed [VALUE_W-1:0] cooling_level,
    input wire logic heat_cool_mode,
    input wire logic start_control,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic [NUM_CH-1:0] alarm_out,
    output logic irq
);
    ////////////////////////////////////////////////////////////////
    logic rst_s1_reg, rst_n;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic [TYPE_W-1:0] type_reg [NUM_CH];
    logic signed [VALUE_W-1:0] thr_reg [NUM_CH];
    logic [9:0] on_dly_reg, off_dly_reg;
    logic [NUM_CH-1:0] status_reg, reject_reg;
    // enable covers alarm and reject bits, same layout as status
    logic [2*NUM_CH-1:0] irq_en_reg;
    logic [NUM_CH-1:0] standby_reg, raw_reg, alarm_reg;
    logic [31:0] samp_cnt_reg, sec_cnt_reg;
    logic [9:0] dly_cnt_reg [NUM_CH];
    logic [15:0] rdata_reg;

    wire sample_tick = (samp_cnt_reg == 32'(SAMPLE_DIV - 1));
    wire sec_tick = (sec_cnt_reg == 32'(SEC_DIV - 1));
    wire wr_type0 = wr && addr == ADDR_TYPE0;
    wire wr_type1 = wr && addr == ADDR_TYPE1;

    // limited: codes above 17 are refused, as is the loop break code on any channel but zero
    function automatic logic code_ok(input logic [TYPE_W-1:0] c, input int ch);
        code_ok = (c <= TYPE_MV_LO) && !(c == TYPE_LOOP && ch != 0);
    endfunction : code_ok

    function automatic logic has_standby(input logic [TYPE_W-1:0] c);
        has_standby = (c == TYPE_DEV_LO_SB) || (c == TYPE_ABS_HI_SB) || (c == TYPE_ABS_LO_SB);
    endfunction : has_standby

    ////////////////////////////////////////////////////////////////
    // signed compare
    logic [NUM_CH-1:0] in_region;
    logic signed [VALUE_W:0] dev_lo;
    always_comb
    begin
        in_region = '0;
        dev_lo = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            dev_lo = (VALUE_W+1)'(target_setpoint) - (VALUE_W+1)'(process_value);
            case (type_reg[i])
                TYPE_DEV_LO, TYPE_DEV_LO_SB: in_region[i] = dev_lo >= (VALUE_W+1)'(thr_reg[i]);
                TYPE_ABS_HI, TYPE_ABS_HI_SB: in_region[i] = process_value > thr_reg[i];
                TYPE_ABS_LO, TYPE_ABS_LO_SB: in_region[i] = process_value < thr_reg[i];
                TYPE_SP_HI: in_region[i] = target_setpoint > thr_reg[i];
                TYPE_SP_LO: in_region[i] = target_setpoint < thr_reg[i];
                TYPE_MV_HI: in_region[i] = output_level > thr_reg[i];
                TYPE_MV_LO: in_region[i] = (heat_cool_mode ? cooling_level : output_level) < thr_reg[i];
                // rate and loop break algorithms not defined; held off
                TYPE_RATE, TYPE_LOOP: in_region[i] = 1'b0;
                default: in_region[i] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp_cnt_reg <= '0;
            sec_cnt_reg <= '0;
        end
        else
        begin
            samp_cnt_reg <= sample_tick ? '0 : samp_cnt_reg + 32'd1;
            sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 32'd1;
        end
    end

    // register file
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            type_reg[0] <= TYPE_RESET;
            type_reg[1] <= TYPE_RESET;
            thr_reg[0] <= '0;
            thr_reg[1] <= '0;
            on_dly_reg <= '0;
            off_dly_reg <= '0;
            irq_en_reg <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            if (wr_type0 && code_ok(wdata[TYPE_W-1:0], 0))
                type_reg[0] <= wdata[TYPE_W-1:0];
            if (wr_type1 && code_ok(wdata[TYPE_W-1:0], 1))
                type_reg[1] <= wdata[TYPE_W-1:0];
            if (wr && addr == ADDR_THR0)
                thr_reg[0] <= wdata;
            if (wr && addr == ADDR_THR1)
                thr_reg[1] <= wdata;
            if (wr && addr == ADDR_ON_DLY)
                on_dly_reg <= (wdata > 16'(DELAY_MAX_S)) ? 10'(DELAY_MAX_S) : wdata[9:0];
            if (wr && addr == ADDR_OFF_DLY)
                off_dly_reg <= (wdata > 16'(DELAY_MAX_S)) ? 10'(DELAY_MAX_S) : wdata[9:0];
            if (wr && addr == ADDR_IRQ_EN)
                irq_en_reg <= wdata[2*NUM_CH-1:0];
            rdata_reg <= '0;
            if (rd)
            begin
                case (addr)
                    ADDR_TYPE0: rdata_reg <= 16'(type_reg[0]);
                    ADDR_THR0: rdata_reg <= thr_reg[0];
                    ADDR_TYPE1: rdata_reg <= 16'(type_reg[1]);
                    ADDR_THR1: rdata_reg <= thr_reg[1];
                    ADDR_ON_DLY: rdata_reg <= 16'(on_dly_reg);
                    ADDR_OFF_DLY: rdata_reg <= 16'(off_dly_reg);
                    ADDR_STATUS: rdata_reg <= 16'({reject_reg, status_reg});
                    ADDR_IRQ_EN: rdata_reg <= 16'(irq_en_reg);
                    ADDR_ALARM: rdata_reg <= 16'(alarm_reg);
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // alarm pipeline per channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_reg <= '1;
            raw_reg <= '0;
            alarm_reg <= '0;
            status_reg <= '0;
            reject_reg <= '0;
            dly_cnt_reg[0] <= '0;
            dly_cnt_reg[1] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                // standby rearms on start or any write to the type register
                if (start_control || (i == 0 ? wr_type0 : wr_type1))
                    standby_reg[i] <= 1'b1;
                else if (sample_tick && !in_region[i])
                    standby_reg[i] <= 1'b0;
                if (sample_tick)
                    raw_reg[i] <= in_region[i] && !(has_standby(type_reg[i]) && standby_reg[i]);
                if (raw_reg[i] == alarm_reg[i])
                    dly_cnt_reg[i] <= '0;
                else if ((raw_reg[i] ? on_dly_reg : off_dly_reg) <= dly_cnt_reg[i])
                begin
                    alarm_reg[i] <= raw_reg[i];
                    dly_cnt_reg[i] <= '0;
                end
                else if (sec_tick)
                    dly_cnt_reg[i] <= dly_cnt_reg[i] + 10'd1;
                // set wins over clear
                if (raw_reg[i] && !alarm_reg[i] && (raw_reg[i] ? on_dly_reg : off_dly_reg) <= dly_cnt_reg[i])
                    status_reg[i] <= 1'b1;
                else if (wr && addr == ADDR_IRQ_CLR && wdata[i])
                    status_reg[i] <= 1'b0;
                if ((i == 0 ? wr_type0 : wr_type1) && !code_ok(wdata[TYPE_W-1:0], i))
                    reject_reg[i] <= 1'b1;
                else if (wr && addr == ADDR_IRQ_CLR && wdata[NUM_CH+i])
                    reject_reg[i] <= 1'b0;
            end
        end
    end

    assign alarm_out = alarm_reg;
    assign rdata = rdata_reg;
    assign irq = |({reject_reg, status_reg} & irq_en_reg);
endmodule : alarm_type_evaluator

// ### alarm_type_evaluator_asserts.sv
`timescale 1ns/1ps
module alarm_type_evaluator_asserts
    import alarm_pkg::*;
#(
    parameter int SAMPLE_DIV = SAMPLE_CYCLES
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic signed [VALUE_W-1:0] process_value,
    input wire logic signed [VALUE_W-1:0] target_setpoint,
    input wire logic signed [VALUE_W-1:0] output_level,
    input wire logic start_control,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic [NUM_CH-1:0] alarm_out
);
    logic [TYPE_W-1:0] type_reg;
    logic signed [VALUE_W-1:0] thr_reg;
    logic [1:0] dz_reg;
    logic q;
    // eight quiet cycles cover a sample period of up to six; the gate allows four or less
    assign q = (SAMPLE_DIV <= 4) && !wr && !start_control && (&dz_reg);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            type_reg <= TYPE_RESET;
            thr_reg <= '0;
            dz_reg <= 2'h3;
        end
        else if (wr)
        begin
            if (addr == ADDR_TYPE0 && wdata <= 16'h0011)
                type_reg <= wdata[TYPE_W-1:0];
            if (addr == ADDR_THR0)
                thr_reg <= wdata;
            if (addr == ADDR_ON_DLY)
                dz_reg[0] <= (wdata == 16'h0000);
            if (addr == ADDR_OFF_DLY)
                dz_reg[1] <= (wdata == 16'h0000);
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_abs_hi_on: assert property ((q && type_reg == TYPE_ABS_HI && process_value > thr_reg) [*8] |-> alarm_out[0])
        else $error("abs upper alarm missing");
    a_abs_hi_off: assert property ((q && type_reg == TYPE_ABS_HI && process_value <= thr_reg) [*8] |-> !alarm_out[0])
        else $error("abs upper alarm wrongly on");
    a_abs_lo_on: assert property ((q && type_reg == TYPE_ABS_LO && process_value < thr_reg) [*8] |-> alarm_out[0])
        else $error("abs lower alarm missing");
    a_dev_lo_on: assert property ((q && type_reg == TYPE_DEV_LO && process_value <= target_setpoint - thr_reg) [*8]
        |-> alarm_out[0])
        else $error("lower deviation alarm missing");
    a_sp_hi_on: assert property ((q && type_reg == TYPE_SP_HI && target_setpoint > thr_reg) [*8] |-> alarm_out[0])
        else $error("setpoint upper alarm missing");
    a_sp_lo_off: assert property ((q && type_reg == TYPE_SP_LO && target_setpoint >= thr_reg) [*8] |-> !alarm_out[0])
        else $error("setpoint lower alarm wrongly on");
    a_mv_hi_on: assert property ((q && type_reg == TYPE_MV_HI && output_level > thr_reg) [*8] |-> alarm_out[0])
        else $error("output upper alarm missing");
    a_off_code: assert property ((q && type_reg == TYPE_OFF) [*8] |-> !alarm_out[0])
        else $error("disabled channel alarm on");
endmodule : alarm_type_evaluator_asserts

// ### alarm_type_evaluator_tb.sv
`timescale 1ns/1ps
module alarm_type_evaluator_tb;
    import alarm_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic signed [VALUE_W-1:0] process_value = '0;
    logic signed [VALUE_W-1:0] target_setpoint = '0;
    logic signed [VALUE_W-1:0] output_level = '0;
    logic signed [VALUE_W-1:0] cooling_level = '0;
    logic heat_cool_mode = 1'b0;
    logic start_control = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [NUM_CH-1:0] alarm_out;
    logic irq;
    logic [15:0] got;
    logic [TYPE_W-1:0] last_code = TYPE_RESET;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    alarm_type_evaluator #(.SAMPLE_DIV(4), .SEC_DIV(20)) uut (.clk(clk), .arst_n(arst_n),
        .process_value(process_value), .target_setpoint(target_setpoint), .output_level(output_level),
        .cooling_level(cooling_level), .heat_cool_mode(heat_cool_mode), .start_control(start_control),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_out(alarm_out), .irq(irq));
    ////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
    endtask : rd_reg
    // levels first, then threshold, then type, so a type write re-arms standby on settled levels
    task automatic step(input logic [TYPE_W-1:0] code, input int pv, sp, mv, cl, input logic hc, input int thr,
        input logic exp);
        @(posedge clk);
        process_value <= 16'(pv);
        target_setpoint <= 16'(sp);
        output_level <= 16'(mv);
        cooling_level <= 16'(cl);
        heat_cool_mode <= hc;
        wr_reg(ADDR_THR0, 16'(thr));
        if (code != last_code)
            wr_reg(ADDR_TYPE0, {11'h000, code});
        last_code = code;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("alarm0", {15'h0000, exp}, {15'h0000, alarm_out[0]});
    endtask : step
    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(ADDR_TYPE1);
        chk("type1 reset", 16'h0002, got);
        wr_reg(ADDR_TYPE1, 16'h000C);
        rd_reg(ADDR_TYPE1);
        chk("type1 kept", 16'h0002, got);
        rd_reg(ADDR_STATUS);
        chk("reject bits", 16'h0008, got & 16'h000C);
        wr_reg(ADDR_IRQ_EN, 16'h0008);
        @(negedge clk);
        chk("irq on", 16'h0001, {15'h0000, irq});
        wr_reg(ADDR_IRQ_CLR, 16'h0008);
        @(negedge clk);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        step(TYPE_ABS_HI, 100, 0, 0, 0, 1'b0, 50, 1'b1);
        step(TYPE_ABS_HI, 50, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_ABS_LO, -10, 0, 0, 0, 1'b0, 0, 1'b1);
        step(TYPE_ABS_LO, 0, 0, 0, 0, 1'b0, 0, 1'b0);
        step(TYPE_DEV_LO, 70, 100, 0, 0, 1'b0, 30, 1'b1);
        step(TYPE_DEV_LO, 71, 100, 0, 0, 1'b0, 30, 1'b0);
        step(TYPE_SP_HI, 0, 10, 0, 0, 1'b0, 5, 1'b1);
        step(TYPE_SP_LO, 0, 10, 0, 0, 1'b0, 5, 1'b0);
        step(TYPE_SP_LO, 0, 4, 0, 0, 1'b0, 5, 1'b1);
        step(TYPE_MV_HI, 0, 0, 60, 99, 1'b1, 50, 1'b1);
        step(TYPE_MV_LO, 0, 0, 60, 40, 1'b1, 50, 1'b1);
        step(TYPE_MV_LO, 0, 0, 60, 40, 1'b0, 50, 1'b0);
        step(TYPE_OFF, 100, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_RATE, 100, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_LOOP, 100, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_ABS_HI_SB, 100, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_ABS_HI_SB, 0, 0, 0, 0, 1'b0, 50, 1'b0);
        step(TYPE_ABS_HI_SB, 100, 0, 0, 0, 1'b0, 50, 1'b1);
        @(posedge clk);
        start_control <= 1'b1;
        @(posedge clk);
        start_control <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("rearmed alarm0", 16'h0000, {15'h0000, alarm_out[0]});
        step(TYPE_ABS_LO_SB, -10, 0, 0, 0, 1'b0, 0, 1'b0);
        step(TYPE_ABS_LO_SB, 10, 0, 0, 0, 1'b0, 0, 1'b0);
        step(TYPE_ABS_LO_SB, -10, 0, 0, 0, 1'b0, 0, 1'b1);
        step(TYPE_DEV_LO_SB, 70, 100, 0, 0, 1'b0, 30, 1'b0);
        step(TYPE_DEV_LO_SB, 100, 100, 0, 0, 1'b0, 30, 1'b0);
        step(TYPE_DEV_LO_SB, 70, 100, 0, 0, 1'b0, 30, 1'b1);
        // two seconds, so the free-running second tick cannot end the delay early
        wr_reg(ADDR_ON_DLY, 16'h0002);
        step(TYPE_ABS_HI, 100, 0, 0, 0, 1'b0, 50, 1'b0);
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk("delayed alarm0", 16'h0001, {15'h0000, alarm_out[0]});
        summarize();
    end
endmodule : alarm_type_evaluator_tb

bind alarm_type_evaluator alarm_type_evaluator_asserts #(.SAMPLE_DIV(SAMPLE_DIV)) watch (.clk(clk), .arst_n(arst_n),
    .process_value(process_value), .target_setpoint(target_setpoint), .output_level(output_level),
    .start_control(start_control), .addr(addr), .wdata(wdata), .wr(wr), .alarm_out(alarm_out));
